/* core/flash_pkg.sv */
// Shared constants and types for the flash program/erase controller and its CPU-side driver
package flash_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam int unsigned ADDR_W        = 24;
  localparam int unsigned OFS_W         = 17;            // 128K byte flash offset
  localparam int unsigned IDX_W         = 15;            // 32-bit word index
  localparam int unsigned FLASH_WORDS   = 32768;
  localparam logic [23:0] LOW_START     = 24'h000000;
  localparam logic [23:0] LOW_END       = 24'h007fff;
  localparam logic [23:0] REMAP_START   = 24'h010000;
  localparam logic [23:0] REMAP_END     = 24'h017fff;
  localparam logic [23:0] HIGH_START    = 24'h018000;
  localparam logic [23:0] HIGH_END      = 24'h02ffff;
  localparam logic [23:0] BANK1_START   = 24'h01c000;
  localparam logic [23:0] BANK2_START   = 24'h028000;
  localparam logic [23:0] BANK3_START   = 24'h02e000;
  localparam logic [23:0] CTL_LOW_END   = 24'h07fffe;
  localparam logic [23:0] CTL_HIGH_END  = 24'h02fffe;
  localparam logic [23:0] CTL_REMAP_END = 24'h017ffe;
  localparam logic [31:0] ERASED_WORD   = 32'hffff_ffff;
  localparam logic [15:0] ERASED_HALF   = 16'hffff;

  // ****************************************************************
  // Control register fields and entry keys
  // ****************************************************************
  localparam int unsigned B_WMODE   = 15;
  localparam int unsigned B_BANK    = 8;
  localparam int unsigned B_WIDTH   = 7;
  localparam int unsigned B_CLK     = 5;
  localparam int unsigned B_SUPPLY  = 4;
  localparam int unsigned B_DROP    = 3;
  localparam int unsigned B_BUSY    = 2;
  localparam int unsigned B_PROTECT = 2;
  localparam int unsigned B_ERASE   = 1;
  localparam int unsigned B_WEN     = 0;
  localparam logic [15:0] KEY_FIRST  = 16'h5a5e;
  localparam logic [15:0] KEY_SECOND = 16'ha5a4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLOCK_NS          = 10;
  localparam int unsigned PROG_PULSE_NS     = 12800;
  localparam int unsigned PROG_PULSE_CYCLES = (PROG_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int unsigned TIMER_W           = 16;
  typedef logic [TIMER_W-1:0] timer_t;

  // ****************************************************************
  // CPU-side driver register map
  // ****************************************************************
  localparam logic [7:0]  REG_ADDR   = 8'h00;
  localparam logic [7:0]  REG_WDATA  = 8'h04;
  localparam logic [7:0]  REG_CTRL   = 8'h08;
  localparam logic [7:0]  REG_STATUS = 8'h0c;
  localparam logic [7:0]  REG_RDATA  = 8'h10;
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_WRITE = 1;
  localparam int unsigned CTRL_FCR   = 2;
  localparam int unsigned CTRL_SRC   = 3;
  localparam int unsigned CTRL_REMAP = 4;

  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_WALK} op_state_e;

endpackage : flash_pkg

/* core/flash_if.sv */
// CPU access channel between the flash controller and the CPU-side driver
`timescale 1ns/1ps
interface flash_if;
  logic        req;        // Held until ack
  logic        we;
  logic        flash_program_control;        // Direct word access aimed at the control register
  logic        src_flash;  // Instruction was fetched from flash
  logic        remap;      // Low 32K mapped to segment 1
  logic [23:0] addr;
  logic [15:0] wdata;
  logic        ack;        // One-cycle answer
  logic [31:0] rdata;
  logic        trap;
  logic        blocked;
  logic        verify;

  modport device (input req, we, flash_program_control, src_flash, remap, addr, wdata,
                  output ack, rdata, trap, blocked, verify);
  modport host   (output req, we, flash_program_control, src_flash, remap, addr, wdata,
                  input ack, rdata, trap, blocked, verify);
endinterface : flash_if

/* core/flash_program_erase_control.sv */
// Flash array with program/erase sequencer and virtually mapped control register
// Function
// RULE1 - Four banks, each erased on its own
// RULE2 - Reset map: low 32K, then 018000h-02FFFFh
// RULE3 - Remap moves low 32K to 010000h-017FFFh
// RULE4 - Array read as 32-bit words
// RULE5 - Timer paces operation, completion indicated
// RULE6 - Control register locked until key sequence
// RULE7 - Default control addresses, even words only
// RULE8 - Remapped control addresses 010000h-017FFEh
// RULE9 - Odd control address raises trap
// RULE10 - Bit 15 writing mode, cleared exits
// RULE11 - Software writes reserved bits as zero
// RULE12 - Bank select bits 9:8 for erase
// RULE13 - Bit 7 selects 16/32-bit programming
// RULE14 - Bits 6:5 set pulse width
// RULE15 - Bit 4 reports supply ok; code reads it as 0 outside writing mode
// RULE16 - Bit 3 latches supply drop during operation
// RULE17 - Bit 2 read shows busy
// RULE18 - Bit 2 write is protect, resets one
// RULE19 - Standard mode: only protect, from flash
// RULE20 - Bit 1 selects erase, does not start
// RULE21 - Bit 0 enables writes, reads verify
// RULE22 - Separate flash access launches operation
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module flash_program_erase_control
  import flash_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PROG_PULSE_CYCLES
) (
  input  wire logic  i_clock,
  input  wire logic  i_rst,
  flash_if.device    bus,
  input  wire logic  i_supply_ok,
  input  wire logic  i_otp_protect,
  output logic       o_writing_mode,
  output logic       o_busy,
  output logic       o_done
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Returns {hit, byte offset into the array}
  function automatic logic [OFS_W:0] flash_map(input logic [23:0] a, input logic rm);
    logic [23:0] d;
    d = 24'h0;
    if (!rm && a <= LOW_END)                    // [RULE2]
      return {1'b1, a[OFS_W-1:0]};
    if (rm && a >= REMAP_START && a <= REMAP_END) begin  // [RULE3]
      d = a - REMAP_START;
      return {1'b1, d[OFS_W-1:0]};
    end
    if (a >= HIGH_START && a <= HIGH_END) begin  // [RULE2]
      d = a - REMAP_START;
      return {1'b1, d[OFS_W-1:0]};
    end
    return '0;
  endfunction : flash_map

  // Word access window of the control register, parity checked apart
  function automatic logic ctl_hit(input logic [23:0] a, input logic rm);
    logic hi;
    hi = (a >= HIGH_START) && (a <= CTL_HIGH_END);
    if (rm)
      return hi || ((a >= REMAP_START) && (a <= CTL_REMAP_END));  // [RULE8]
    return hi || (a <= CTL_LOW_END);                               // [RULE7]
  endfunction : ctl_hit

  // First word index of a bank; bank 0 covers the low 32K plus 018000h-01BFFFh
  function automatic logic [IDX_W:0] bank_first(input logic [2:0] b);
    logic [23:0] s;
    case (b)
      3'h0:    s = REMAP_START;
      3'h1:    s = BANK1_START;
      3'h2:    s = BANK2_START;
      3'h3:    s = BANK3_START;
      default: s = HIGH_END + 24'h1;
    endcase
    s = s - REMAP_START;
    return s[OFS_W:2];  // [RULE1]
  endfunction : bank_first

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0]      mem [FLASH_WORDS];
  op_state_e        state_q, state_d;
  timer_t           timer_q, timer_d;
  logic             wmode_q, wmode_d, key_q, key_d, protect_q, protect_d;
  logic [1:0]       bank_q, bank_d, clk_q, clk_d;
  logic             width_q, width_d, erase_q, erase_d, wen_q, wen_d, drop_q, drop_d;
  logic [IDX_W-1:0] idx_q, idx_d, end_q, end_d;
  logic [31:0]      pdata_q, pdata_d;
  logic [15:0]      lo_q, lo_d;
  logic             lo_ok_q, lo_ok_d;
  logic             ack_q, ack_d, trap_q, trap_d, blk_q, blk_d, ver_q, ver_d;
  logic [31:0]      rdata_q, rdata_d;
  logic             done_q, done_d, busy_q, busy_d;
  logic             mem_we;
  logic [31:0]      mem_wdata;
  logic [OFS_W:0]   map;
  logic             take, idle;
  logic [IDX_W:0]   b_lo, b_hi;
  logic [IDX_W-1:0] widx;
  assign map  = flash_map(bus.addr, bus.remap);
  assign take = bus.req && !ack_q;
  assign idle = (state_q == ST_IDLE);
  assign b_lo = bank_first({1'b0, bank_q});
  assign b_hi = bank_first({1'b0, bank_q} + 3'h1);
  assign widx = map[OFS_W-1:2];
  // Array starts out erased
  initial begin
    for (int i = 0; i < FLASH_WORDS; i++) begin
      mem[i] = ERASED_WORD;
    end
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    state_d = state_q;  timer_d = timer_q;  wmode_d = wmode_q;  key_d = key_q;
    protect_d = protect_q;  bank_d = bank_q;  clk_d = clk_q;  width_d = width_q;
    erase_d = erase_q;  wen_d = wen_q;  drop_d = drop_q;  idx_d = idx_q;
    end_d = end_q;  pdata_d = pdata_q;  lo_d = lo_q;  lo_ok_d = lo_ok_q;
    ack_d = 1'b0;  trap_d = 1'b0;  blk_d = 1'b0;  ver_d = 1'b0;  rdata_d = '0;
    done_d = 1'b0;  mem_we = 1'b0;  mem_wdata = ERASED_WORD;

    // Operation sequencer
    case (state_q)
      ST_PULSE: begin
        if (timer_q == '0) begin                         // [RULE5]
          if (erase_q) begin
            state_d = ST_WALK;
          end else begin
            mem_we    = 1'b1;
            mem_wdata = mem[idx_q] & pdata_q;  // Programming only clears bits
            state_d   = ST_IDLE;
            done_d    = 1'b1;                            // [RULE5]
          end
        end else begin
          timer_d = timer_q - timer_t'(1);
        end
      end
      ST_WALK: begin
        mem_we = 1'b1;                                   // [RULE1]
        idx_d  = idx_q + 1'b1;
        if (idx_q == end_q) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;                                // [RULE5]
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // Supply sagging at any time during an operation is remembered
    if (!idle && !i_supply_ok)
      drop_d = 1'b1;                                     // [RULE16]

    // CPU access handling
    if (take) begin
      ack_d = 1'b1;
      if (bus.flash_program_control) begin
        if (ctl_hit(bus.addr, bus.remap) && bus.addr[0]) begin
          trap_d = 1'b1;                                 // [RULE9]
        end else if (ctl_hit(bus.addr, bus.remap) && !bus.we) begin
          rdata_d[B_WMODE]        = wmode_q;
          rdata_d[B_BANK+:2]      = bank_q;
          rdata_d[B_WIDTH]        = width_q;
          rdata_d[B_CLK+:2]       = clk_q;
          rdata_d[B_SUPPLY]       = wmode_q && i_supply_ok;  // [RULE15]
          rdata_d[B_DROP]         = drop_q;
          rdata_d[B_BUSY]         = !idle;               // [RULE17]
          rdata_d[B_ERASE]        = erase_q;
          rdata_d[B_WEN]          = wen_q;
        end else if (ctl_hit(bus.addr, bus.remap) && !wmode_q) begin
          // Locked: only the key pair and the protect bit get through
          key_d = (bus.wdata == KEY_FIRST);              // [RULE6]
          if (key_q && bus.wdata == KEY_SECOND)
            wmode_d = 1'b1;                              // [RULE10]
          else if (bus.wdata != KEY_FIRST && bus.src_flash)
            protect_d = bus.wdata[B_PROTECT];            // [RULE19]
        end else if (ctl_hit(bus.addr, bus.remap) && idle) begin
          // Reserved bits 14:10 are simply not stored
          if (!bus.wdata[B_WMODE]) begin
            wmode_d = 1'b0;                              // [RULE10]
            wen_d   = 1'b0;
            erase_d = 1'b0;
          end else begin
            bank_d    = bus.wdata[B_BANK+:2];            // [RULE12]
            width_d   = bus.wdata[B_WIDTH];              // [RULE13]
            clk_d     = bus.wdata[B_CLK+:2];             // [RULE14]
            protect_d = bus.wdata[B_PROTECT];            // [RULE18]
            erase_d   = bus.wdata[B_ERASE];              // [RULE20]
            wen_d     = bus.wdata[B_WEN];                // [RULE21]
          end
          lo_ok_d = 1'b0;
        end
      end else if (map[OFS_W] && protect_q && i_otp_protect && !bus.src_flash) begin
        blk_d = 1'b1;                                    // [RULE18]
      end else if (map[OFS_W] && !bus.we) begin
        rdata_d = mem[widx];                             // [RULE4]
        ver_d   = wen_q;                                 // [RULE21]
      end else if (map[OFS_W] && wmode_q && wen_q && idle) begin
        // Mode bits only select; this separate write launches
        timer_d = timer_t'((PULSE_CYCLES << clk_q) - 1);  // [RULE14]
        drop_d  = !i_supply_ok;                          // [RULE16]
        if (erase_q) begin
          state_d = ST_PULSE;                            // [RULE22]
          idx_d   = b_lo[IDX_W-1:0];                     // [RULE12]
          end_d   = b_hi[IDX_W-1:0] - 1'b1;
        end else if (!width_q) begin
          state_d = ST_PULSE;                            // [RULE22]
          idx_d   = widx;
          pdata_d = map[1] ? {bus.wdata, ERASED_HALF} : {ERASED_HALF, bus.wdata};
        end else if (!map[1]) begin
          lo_d    = bus.wdata;                           // [RULE13]
          lo_ok_d = 1'b1;
          drop_d  = drop_q;
        end else if (lo_ok_q) begin
          state_d = ST_PULSE;                            // [RULE22]
          idx_d   = widx;
          pdata_d = {bus.wdata, lo_q};
          lo_ok_d = 1'b0;
        end else begin
          drop_d  = drop_q;
        end
      end
    end
    busy_d = (state_d != ST_IDLE);                       // [RULE17]
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= ST_IDLE;  timer_q <= '0;  wmode_q <= 1'b0;  key_q <= 1'b0;
      protect_q <= 1'b1;  bank_q <= '0;  clk_q <= '0;  width_q <= 1'b0;
      erase_q <= 1'b0;  wen_q <= 1'b0;  drop_q <= 1'b0;  idx_q <= '0;
      end_q <= '0;  pdata_q <= ERASED_WORD;  lo_q <= '0;  lo_ok_q <= 1'b0;
      ack_q <= 1'b0;  trap_q <= 1'b0;  blk_q <= 1'b0;  ver_q <= 1'b0;
      rdata_q <= '0;  done_q <= 1'b0;  busy_q <= 1'b0;
    end else begin
      state_q <= state_d;  timer_q <= timer_d;  wmode_q <= wmode_d;  key_q <= key_d;
      protect_q <= protect_d;  bank_q <= bank_d;  clk_q <= clk_d;  width_q <= width_d;
      erase_q <= erase_d;  wen_q <= wen_d;  drop_q <= drop_d;  idx_q <= idx_d;
      end_q <= end_d;  pdata_q <= pdata_d;  lo_q <= lo_d;  lo_ok_q <= lo_ok_d;
      ack_q <= ack_d;  trap_q <= trap_d;  blk_q <= blk_d;  ver_q <= ver_d;
      rdata_q <= rdata_d;  done_q <= done_d;  busy_q <= busy_d;
    end
  end

  // Array write port; plain always as the initial fill writes the array too
  always @(posedge i_clock) begin
    if (mem_we && !i_rst) begin
      mem[idx_q] <= mem_wdata;
    end
  end

  assign bus.ack       = ack_q;
  assign bus.rdata     = rdata_q;
  assign bus.trap      = trap_q;
  assign bus.blocked   = blk_q;
  assign bus.verify    = ver_q;
  assign o_writing_mode = wmode_q;
  assign o_busy        = busy_q;
  assign o_done        = done_q;

endmodule : flash_program_erase_control

/* core/flash_cpu_driver.sv */
// CPU-side driver: APB registers that issue accesses to the flash controller
`timescale 1ns/1ps
module flash_cpu_driver
  import flash_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  flash_if.host            bus
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [23:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic        we_q, we_d, fcr_q, fcr_d, src_q, src_d, remap_q, remap_d;
  logic        req_q, req_d, trap_q, trap_d, blk_q, blk_d, ver_q, ver_d;
  logic [31:0] rd_q, rd_d, prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic        access;

  // One wait state: answer registered in the cycle after setup
  assign access = i_psel && i_penable && !pready_q;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    addr_d = addr_q;  wdata_d = wdata_q;  we_d = we_q;  fcr_d = fcr_q;
    src_d = src_q;  remap_d = remap_q;  req_d = req_q;  trap_d = trap_q;
    blk_d = blk_q;  ver_d = ver_q;  rd_d = rd_q;
    prdata_d = '0;  pready_d = 1'b0;  pslverr_d = 1'b0;

    // Request held until the controller answers
    if (req_q && bus.ack) begin
      req_d = 1'b0;
      rd_d  = bus.rdata;
      trap_d = bus.trap;    // [RULE9]
      blk_d  = bus.blocked;
      ver_d  = bus.verify;  // [RULE21]
    end

    if (access) begin
      pready_d = 1'b1;
      case (i_paddr)
        REG_ADDR:   if (i_pwrite) addr_d = i_pwdata[23:0];
                    else prdata_d = {8'h00, addr_q};
        REG_WDATA:  if (i_pwrite) wdata_d = i_pwdata[15:0];  // [RULE11]
                    else prdata_d = {16'h0000, wdata_q};
        REG_CTRL: begin
          if (i_pwrite && !req_q) begin
            we_d    = i_pwdata[CTRL_WRITE];
            fcr_d   = i_pwdata[CTRL_FCR];   // Word access only [RULE7]
            src_d   = i_pwdata[CTRL_SRC];
            remap_d = i_pwdata[CTRL_REMAP]; // [RULE3]
            if (i_pwdata[CTRL_START]) begin
              req_d  = 1'b1;                // [RULE22]
              trap_d = 1'b0;
              blk_d  = 1'b0;
              ver_d  = 1'b0;
            end
          end else if (!i_pwrite) begin
            prdata_d[CTRL_WRITE] = we_q;
            prdata_d[CTRL_FCR]   = fcr_q;
            prdata_d[CTRL_SRC]   = src_q;
            prdata_d[CTRL_REMAP] = remap_q;
          end
        end
        REG_STATUS: prdata_d = {28'h0000000, ver_q, blk_q, trap_q, req_q};
        REG_RDATA:  prdata_d = rd_q;
        default:    pslverr_d = 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      addr_q <= '0;  wdata_q <= '0;  we_q <= 1'b0;  fcr_q <= 1'b0;
      src_q <= 1'b1;  remap_q <= 1'b0;  req_q <= 1'b0;  trap_q <= 1'b0;
      blk_q <= 1'b0;  ver_q <= 1'b0;  rd_q <= '0;
      prdata_q <= '0;  pready_q <= 1'b0;  pslverr_q <= 1'b0;
    end else begin
      addr_q <= addr_d;  wdata_q <= wdata_d;  we_q <= we_d;  fcr_q <= fcr_d;
      src_q <= src_d;  remap_q <= remap_d;  req_q <= req_d;  trap_q <= trap_d;
      blk_q <= blk_d;  ver_q <= ver_d;  rd_q <= rd_d;
      prdata_q <= prdata_d;  pready_q <= pready_d;  pslverr_q <= pslverr_d;
    end
  end

  assign bus.req       = req_q;
  assign bus.we        = we_q;
  assign bus.flash_program_control       = fcr_q;
  assign bus.src_flash = src_q;
  assign bus.remap     = remap_q;
  assign bus.addr      = addr_q;
  assign bus.wdata     = wdata_q;
  assign o_prdata      = prdata_q;
  assign o_pready      = pready_q;
  assign o_pslverr     = pslverr_q;

endmodule : flash_cpu_driver

/* test/flash_program_erase_control_asserts.sv */
// Concurrent checks on the channel between CPU driver and flash controller
`timescale 1ns/1ps
module flash_program_erase_control_asserts (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        req,
  input wire logic        we,
  input wire logic        flash_program_control,
  input wire logic        src_flash,
  input wire logic [23:0] addr,
  input wire logic        ack,
  input wire logic        trap,
  input wire logic        blocked,
  input wire logic        verify,
  input wire logic        o_writing_mode,
  input wire logic        o_busy,
  input wire logic        o_done
);
  // ****************************************
  // Channel and sequencer properties
  // ****************************************
  // Single domain, so clock and reset are stated once
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  AST_ACK_NEXT: assert property (req && !ack |=> ack)
    else $error("access not answered in next cycle");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("answer held longer than one cycle");
  AST_TRAP_ODD: assert property (req && !ack && flash_program_control && addr[0] |=> trap)
    else $error("odd control address without trap");
  AST_TRAP_CAUSE: assert property (trap |-> ack && $past(flash_program_control && addr[0]))
    else $error("trap without odd control address");
  AST_VERIFY_CAUSE: assert property (verify |-> ack && !$past(flash_program_control))
    else $error("verify flag on a non-array access");
  AST_BLOCK_CAUSE: assert property (blocked |-> ack && !$past(src_flash))
    else $error("access from flash code was blocked");
  AST_DONE_END: assert property (o_done |-> $past(o_busy) ##1 !o_done)
    else $error("completion without running operation");
  AST_WMODE_ENTRY: assert property ($rose(o_writing_mode) |-> $past(req && we && flash_program_control))
    else $error("writing mode entered without control write");
endmodule : flash_program_erase_control_asserts

/* test/flash_program_erase_control_test.sv */
// Self-checking bench: APB-driven CPU end facing the flash controller
`timescale 1ns/1ps
module flash_program_erase_control_test;
  import flash_pkg::*;
  logic        i_clock = 1'b0, i_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, st;
  logic        pready, pslverr, e, sup_ok = 1'b1, otp = 1'b0, wmode, busy, done;
  int          n_fail = 0, checks_done = 0;
  flash_if fif();
  flash_cpu_driver flash_cpu_driver_i (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .bus(fif));
  // Short pulse keeps program operations within the 100-cycle wait_idle budget
  flash_program_erase_control #(.PULSE_CYCLES(4)) flash_program_erase_control_i (
    .i_clock(i_clock), .i_rst(i_rst), .bus(fif), .i_supply_ok(sup_ok),
    .i_otp_protect(otp), .o_writing_mode(wmode), .o_busy(busy), .o_done(done));
  flash_program_erase_control_asserts flash_program_erase_control_asserts_i (
    .i_clock(i_clock), .i_rst(i_rst), .req(fif.req), .we(fif.we), .flash_program_control(fif.flash_program_control),
    .src_flash(fif.src_flash), .addr(fif.addr), .ack(fif.ack), .trap(fif.trap),
    .blocked(fif.blocked), .verify(fif.verify), .o_writing_mode(wmode),
    .o_busy(busy), .o_done(done));
  // 100 MHz clock
  always #5 i_clock = ~i_clock;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; pready is judged at the rising edge that completes it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge i_clock); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin n_fail++; results(); end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clock);
  endtask : apb
  // Flash access; c is {remap, src_flash, fcr, write}
  task automatic acc(input logic [3:0] c, input logic [23:0] a, input logic [15:0] d);
    int k;
    apb(1'b1, REG_ADDR, {8'h00, a});
    apb(1'b1, REG_WDATA, {16'h0, d});
    apb(1'b1, REG_CTRL, {27'h0, c, 1'b1});
    k = 0;
    do begin apb(1'b0, REG_STATUS, 32'h0); k++; end while (q[0] !== 1'b0 && k < 20);
    if (k >= 20) begin n_fail++; results(); end
    st = q;
    apb(1'b0, REG_RDATA, 32'h0);
  endtask : acc
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    do begin @(negedge i_clock); k++; end while (busy !== 1'b0 && k < lim);
    if (k >= lim) begin n_fail++; results(); end
    e = done;
    @(posedge i_clock);
  endtask : wait_idle
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_locked();
    apb(1'b0, 8'h20, 32'h0);
    chk(e, 1'b1);
    acc(4'b0111, 24'h000000, 16'h8001);
    acc(4'b0110, 24'h000000, 16'h0);
    chk(q, 32'h0);
    acc(4'b0110, 24'h000001, 16'h0);
    chk(st[1], 1'b1);
    chk(wmode, 1'b0);
  endtask : sc_locked
  task automatic sc_program();
    acc(4'b0111, 24'h000000, KEY_FIRST);
    acc(4'b0111, 24'h000000, KEY_SECOND);
    chk(wmode, 1'b1);
    acc(4'b0111, 24'h018000, 16'h8001);
    chk(busy, 1'b0);
    acc(4'b0110, 24'h02fffe, 16'h0);
    chk(q, 32'h8011);
    acc(4'b1110, 24'h017ffe, 16'h0);
    chk(q, 32'h8011);
    acc(4'b0101, 24'h000100, 16'h1234);
    wait_idle(100);
    acc(4'b0101, 24'h02e000, 16'h5678);
    wait_idle(100);
    acc(4'b0100, 24'h02e000, 16'h0);
    chk(q, 32'hffff5678);
    acc(4'b1100, 24'h010100, 16'h0);
    chk(q, 32'hffff1234);
    chk(st[3], 1'b1);
    acc(4'b0111, 24'h018000, 16'h8081);
    acc(4'b0101, 24'h000200, 16'haaaa);
    acc(4'b0101, 24'h000202, 16'h5555);
    wait_idle(100);
    acc(4'b0100, 24'h000200, 16'h0);
    chk(q, 32'h5555aaaa);
  endtask : sc_program
  // Bank 3 erase with a supply dip while it runs
  task automatic sc_erase();
    acc(4'b0111, 24'h000000, 16'h8303);
    acc(4'b0101, 24'h02e000, 16'h0);
    chk(busy, 1'b1);
    sup_ok <= 1'b0;
    repeat (3) @(posedge i_clock);
    sup_ok <= 1'b1;
    wait_idle(5000);
    chk(e, 1'b1);
    acc(4'b0110, 24'h000000, 16'h0);
    chk(q, 32'h831b);
    acc(4'b0100, 24'h000100, 16'h0);
    chk(q, 32'hffff1234);
    acc(4'b0100, 24'h02e000, 16'h0);
    chk(q, 32'hffffffff);
  endtask : sc_erase
  task automatic sc_protect();
    acc(4'b0111, 24'h000000, 16'h0004);
    chk(wmode, 1'b0);
    acc(4'b0111, 24'h000000, 16'h0004);
    otp <= 1'b1;
    acc(4'b0000, 24'h000100, 16'h0);
    chk(st[2], 1'b1);
    acc(4'b0100, 24'h000100, 16'h0);
    chk(q, 32'hffff1234);
    chk(st[3], 1'b0);
    acc(4'b0011, 24'h000000, 16'h0000);
    acc(4'b0000, 24'h000100, 16'h0);
    chk(st[2], 1'b1);
    acc(4'b0111, 24'h000000, 16'h0000);
    acc(4'b0000, 24'h000100, 16'h0);
    chk(st[2], 1'b0);
  endtask : sc_protect
  // Main sequence
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    sc_locked();
    sc_program();
    sc_erase();
    sc_protect();
    results();
  end
endmodule : flash_program_erase_control_test
